/* logic/adcsb_pkg.sv */
/*
 * adcsb_pkg: register map, field layout, codes and carriers of the
 * converter scan/buffer sequencer.
 * assumes: imported whole by every design file of the block.
 */
package adcsb_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CSR = 8'h00;
  localparam logic [7:0] OFS_CR = 8'h04;
  localparam logic [7:0] OFS_RES = 8'h10;
  localparam logic [7:0] OFS_RES_END = 8'h2c;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int CSR_FLAG = 7;
  localparam int CR_BUF_LSB = 0;
  localparam int CR_TRG_LSB = 4;
  localparam int CR_CNT_LSB = 8;
  localparam int RES_W = 10;
  localparam int NCH = 8;

  // ------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] BUF_NONE = 2'h0;
  localparam logic [1:0] BUF_TWO1 = 2'h1;
  localparam logic [1:0] BUF_TWO2 = 2'h2;
  localparam logic [1:0] BUF_FOUR = 2'h3;
  localparam logic [1:0] TRG_SW = 2'h0;
  localparam logic [1:0] TRG_TMR = 2'h1;
  localparam logic [1:0] TRG_EXT = 2'h3;
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [1:0] BUF_RESET = BUF_NONE;
  localparam logic [1:0] TRG_RESET = TRG_SW;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic ie;
    logic start;
    logic group_mode_select;
    logic scan;
    logic [2:0] ch;
  } adcsb_csr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] chan;
  } adcsb_req_t;

  typedef struct packed {
    logic valid;
    logic [RES_W-1:0] data;
  } adcsb_done_t;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT, ST_PAUSE} adcsb_state_t;

endpackage : adcsb_pkg

/* logic/adcsb_sync.sv */
/*
 * adcsb_sync: three-stage synchroniser for the external start pin,
 * giving a one-cycle pulse on an accepted rising level.
 * assumes: pin is asynchronous to clk.
 */
`timescale 1ns/10ps
module adcsb_sync
  import adcsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin_in,
  output logic rise
);

  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic level_reg;
  logic level_next;
  logic rise_reg;
  logic rise_next;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // stage 0 feeds stage 1 only; a change counts once 1 and 2 agree
  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
    level_next = level_reg;
    rise_next = 1'b0;
    if (sync_reg[1] == sync_reg[2]) begin
      level_next = sync_reg[2];
      rise_next = sync_reg[2] & ~level_reg;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= 3'h0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      level_reg <= level_next;
      rise_reg <= rise_next;
    end
  end

  assign rise = rise_reg;

endmodule : adcsb_sync

/* logic/adcsb_results.sv */
/*
 * adcsb_results: the eight result registers and the buffer chains.
 * assumes: wr.valid is a one-cycle pulse with the converted data.
 */
`timescale 1ns/10ps
module adcsb_results
  import adcsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire adcsb_done_t wr,
  input wire logic [2:0] wr_chan,
  input wire logic [1:0] buf_mode,
  output logic [NCH-1:0][RES_W-1:0] res
);

  logic [NCH-1:0][RES_W-1:0] res_reg;
  logic [NCH-1:0][RES_W-1:0] res_next;

  // ------------------------------------------------------------
  // per-entry store and shift
  // ------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ent
    localparam int S1 = (i > 0) ? i - 1 : 0;
    localparam int S2 = (i > 1) ? i - 2 : 0;
    logic sh1;
    logic sh2;
    // chain moves old value along as the head takes the new one
    always_comb begin
      sh1 = (wr_chan == 3'h0) && (i >= 1) && ((buf_mode == BUF_TWO1 && i == 1)
            || (buf_mode == BUF_FOUR && i <= 3));
      sh2 = (buf_mode == BUF_TWO2) && ((i == 2 && wr_chan == 3'h0)
            || (i == 3 && wr_chan == 3'h1));
      res_next[i] = res_reg[i];
      if (wr.valid) begin
        if (wr_chan == 3'(i)) begin
          res_next[i] = wr.data;
        end else if (sh1) begin
          res_next[i] = res_reg[S1];
        end else if (sh2) begin
          res_next[i] = res_reg[S2];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      res_reg <= '0;
    end else begin
      res_reg <= res_next;
    end
  end

  assign res = res_reg;

endmodule : adcsb_results

/* logic/adcsb_top.sv */
/*
 * adcsb_top: apb register slave and scan/buffer sequencer of a 10-bit
 * converter. issues one conversion request at a time to the core.
 * assumes: conv_done is a one-cycle pulse on clk some cycles after a
 * request; timer_trig is a same-clock pulse; ext_trig_pin is async.
 */
`timescale 1ns/10ps

// Contract
// - group scan repeats until software clears start
// - group scan sets flag after first pass
// - flag with enable raises irq, pauses scan
// - paused scan resumes when flag cleared
// - flag cleared by read then write0, or by transfer-mode last result read
// - buffered result enters head, old shifts
// - three chains: A-B, A-C/B-D, A-B-C-D
// - buffer-only: channel select sets pass count
// - two-stage codes end after one/two passes
// - four-stage ends after one to four
// - single stops at flag, scan continues
// - select single buffered: standby each cycle
// - combined mode adds group inputs 4..ch, 2..ch with code 01
// - combined mode shifts A-C into B-D
// - code 01 combined converts 0,2..ch
// - other combined codes convert 0,(1),4..ch
// - transfer mode: last result read clears flag
// - buffer code 00 when halted clears count
// - flag with enable issues interrupt request
// - buffer code 00 normal, reset value
module adcsb_top
  import adcsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_trig,
  input wire logic ext_trig_pin,
  input wire logic xfer_ctrl_mode,
  output adcsb_req_t conv_req,
  input wire adcsb_done_t conv_done,
  output logic conversion_end_irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  adcsb_csr_t csr_reg;
  adcsb_csr_t csr_next;
  logic [1:0] buf_reg;
  logic [1:0] buf_next;
  logic [1:0] trg_reg;
  logic [1:0] trg_next;
  logic [2:0] pass_cnt_reg;
  logic [2:0] pass_cnt_next;
  logic [2:0] step_reg;
  logic [2:0] step_next;
  adcsb_state_t state_reg;
  adcsb_state_t state_next;
  logic armed_reg;
  logic armed_next;
  adcsb_req_t req_reg;
  adcsb_req_t req_next;
  logic irq_reg;
  logic irq_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  logic ext_rise;
  logic [NCH-1:0][RES_W-1:0] res;
  adcsb_done_t store;

  // ------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------
  adcsb_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin_in(ext_trig_pin),
    .rise(ext_rise)
  );

  adcsb_results u_res (
    .clk(clk),
    .nrst(nrst),
    .wr(store),
    .wr_chan(req_reg.chan),
    .buf_mode(buf_reg),
    .res(res)
  );

  // ------------------------------------------------------------
  // sequence decode
  // ------------------------------------------------------------
  logic combined;
  logic buf_only;
  logic [3:0] n_steps;
  logic [2:0] pass_target;
  logic [2:0] last_chan;
  logic last_step;

  // channel converted at step s under the current settings
  function automatic logic [2:0] step_chan(input logic [2:0] s, input logic [1:0] bm,
                                          input logic comb, input adcsb_csr_t c);
    logic [2:0] r;
    r = 3'h0;
    case (bm)
      BUF_NONE: r = c.group_mode_select ? s : c.ch;
      BUF_TWO1: r = (comb && s != 3'h0) ? 3'(s + 3'h1) : 3'h0;
      BUF_TWO2: r = (comb && s >= 3'h2) ? 3'(s + 3'h2) : {2'h0, s[0]};
      BUF_FOUR: r = (comb && s != 3'h0) ? 3'(s + 3'h3) : 3'h0;
      default: r = 3'h0;
    endcase
    return r;
  endfunction : step_chan

  always_comb begin
    combined = csr_reg.group_mode_select && ((buf_reg == BUF_TWO1 && csr_reg.ch >= 3'h2)
               || (buf_reg != BUF_TWO1 && csr_reg.ch[2]));
    buf_only = (buf_reg != BUF_NONE) && !combined;
    // unlisted code pairs fall back to these figures unchecked
    case (buf_reg)
      BUF_NONE: n_steps = csr_reg.group_mode_select ? 4'({1'b0, csr_reg.ch} + 4'h1) : 4'h1;
      BUF_TWO1: n_steps = combined ? {1'b0, csr_reg.ch} : 4'h1;
      BUF_TWO2: n_steps = combined ? 4'({1'b0, csr_reg.ch} - 4'h1) : 4'h2;
      BUF_FOUR: n_steps = combined ? 4'({1'b0, csr_reg.ch} - 4'h2) : 4'h1;
      default: n_steps = 4'h1;
    endcase
    pass_target = 3'h1;
    if (buf_only) begin
      case (buf_reg)
        BUF_TWO1: pass_target = 3'({2'h0, csr_reg.ch[0]} + 3'h1);
        BUF_TWO2: pass_target = 3'({2'h0, csr_reg.ch[1]} + 3'h1);
        BUF_FOUR: pass_target = 3'({1'b0, csr_reg.ch[1:0]} + 3'h1);
        default: pass_target = 3'h1;
      endcase
    end
    last_chan = step_chan(3'(n_steps - 4'h1), buf_reg, combined, csr_reg);
    // buffer-only: the chain's final register, not the last input converted
    if (buf_only) begin
      case (buf_reg)
        BUF_TWO2: last_chan = {1'b0, csr_reg.ch[1], 1'b1};
        default: last_chan = 3'(pass_target - 3'h1);
      endcase
    end
    last_step = ({1'b0, step_reg} + 4'h1) >= n_steps;
  end

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic setup;
  logic acc;
  logic hit_csr;
  logic hit_cr;
  logic hit_res;
  logic [2:0] res_idx;
  logic [7:0] res_ofs;
  logic [31:0] rd_mux;

  always_comb begin
    setup = psel && !penable;
    acc = psel && penable && pready_reg;
    hit_csr = paddr == OFS_CSR;
    hit_cr = paddr == OFS_CR;
    hit_res = paddr >= OFS_RES && paddr <= OFS_RES_END && paddr[1:0] == 2'h0;
    res_ofs = paddr - OFS_RES;
    res_idx = res_ofs[4:2];
    rd_mux = 32'h0;
    if (hit_csr) begin
      rd_mux[7:0] = csr_reg;
    end else if (hit_cr) begin
      rd_mux[CR_BUF_LSB +: 2] = buf_reg;
      rd_mux[CR_TRG_LSB +: 2] = trg_reg;
      rd_mux[CR_CNT_LSB +: 3] = pass_cnt_reg;
    end else if (hit_res) begin
      rd_mux[RES_W-1:0] = res[res_idx];
    end
  end

  // zero-wait slave: data and ready prepared in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (setup) begin
      pready_next = 1'b1;
      pslverr_next = !(hit_csr || hit_cr || hit_res) || (pwrite && hit_res);
      prdata_next = pwrite ? 32'h0 : rd_mux;
    end
  end

  // ------------------------------------------------------------
  // control and sequencer
  // ------------------------------------------------------------
  logic done_ok;
  logic end_now;
  logic trig;

  always_comb begin
    csr_next = csr_reg;
    buf_next = buf_reg;
    trg_next = trg_reg;
    pass_cnt_next = pass_cnt_reg;
    step_next = step_reg;
    state_next = state_reg;
    armed_next = armed_reg;
    req_next = '{valid: 1'b0, chan: req_reg.chan};
    end_now = 1'b0;
    trig = (trg_reg == TRG_TMR && timer_trig) || (trg_reg == TRG_EXT && ext_rise);
    done_ok = state_reg == ST_WAIT && conv_done.valid && csr_reg.start;
    store = '{valid: done_ok, data: conv_done.data};

    // register writes and flag clearing
    if (acc && pwrite && hit_csr) begin
      csr_next.ie = pwdata[6];
      csr_next.start = pwdata[5];
      csr_next.group_mode_select = pwdata[4];
      csr_next.scan = pwdata[3];
      csr_next.ch = pwdata[2:0];
      if (armed_reg && !pwdata[CSR_FLAG]) begin
        csr_next.flag = 1'b0;
      end
      armed_next = 1'b0;
    end
    if (acc && !pwrite && hit_csr && prdata_reg[CSR_FLAG]) begin
      armed_next = 1'b1;
    end
    if (acc && pwrite && hit_cr) begin
      buf_next = pwdata[CR_BUF_LSB +: 2];
      trg_next = pwdata[CR_TRG_LSB +: 2];
      if (pwdata[CR_BUF_LSB +: 2] == BUF_NONE && !csr_reg.start) begin
        pass_cnt_next = 3'h0;
      end
    end
    // reading the final result on behalf of the transfer engine
    if (acc && !pwrite && hit_res && xfer_ctrl_mode && res_idx == last_chan) begin
      csr_next.flag = 1'b0;
    end
    if (trig) begin
      csr_next.start = 1'b1;
    end

    case (state_reg)
      ST_IDLE: begin
        step_next = 3'h0;
        if (csr_reg.start) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        req_next = '{valid: 1'b1, chan: step_chan(step_reg, buf_reg, combined, csr_reg)};
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (done_ok) begin
          state_next = ST_REQ;
          step_next = 3'(step_reg + 3'h1);
          if (last_step) begin
            step_next = 3'h0;
            if (pass_cnt_reg + 3'h1 >= pass_target) begin
              pass_cnt_next = 3'h0;
              end_now = 1'b1;
            end else begin
              pass_cnt_next = 3'(pass_cnt_reg + 3'h1);
            end
            if (!csr_reg.scan) begin
              // select single with a chain idles after every pass
              if (end_now || (!csr_reg.group_mode_select && buf_reg != BUF_NONE)) begin
                csr_next.start = 1'b0;
                state_next = ST_IDLE;
              end
            end else if (end_now && csr_reg.ie) begin
              state_next = ST_PAUSE;
            end else begin
              state_next = ST_REQ;
            end
          end
        end
      end
      ST_PAUSE: begin
        if (!csr_reg.flag) begin
          state_next = ST_REQ;
        end
      end
      default: state_next = ST_IDLE;
    endcase

    // a flag set in the same cycle as its clear survives
    if (end_now) begin
      csr_next.flag = 1'b1;
    end
    if (!csr_next.start) begin
      state_next = ST_IDLE;
    end
    irq_next = csr_next.flag && csr_next.ie;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      csr_reg <= CSR_RESET;
      buf_reg <= BUF_RESET;
      trg_reg <= TRG_RESET;
      pass_cnt_reg <= 3'h0;
      step_reg <= 3'h0;
      state_reg <= ST_IDLE;
      armed_reg <= 1'b0;
      req_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      csr_reg <= csr_next;
      buf_reg <= buf_next;
      trg_reg <= trg_next;
      pass_cnt_reg <= pass_cnt_next;
      step_reg <= step_next;
      state_reg <= state_next;
      armed_reg <= armed_next;
      req_reg <= req_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign conv_req = req_reg;
  assign conversion_end_irq = irq_reg;

endmodule : adcsb_top

/* testbench/adcsb_props.sv */
/*
 * adcsb_props: port-level assertions of the scan/buffer sequencer.
 * assumes: bound to adcsb_top; one clock, async active-low reset.
 */
`timescale 1ns/10ps
module adcsb_props
  import adcsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adcsb_req_t conv_req,
  input wire adcsb_done_t conv_done,
  input wire logic conversion_end_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // bus and link timing
  // ----------------------------------------
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_req_pulse: assert property (conv_req.valid |=> !conv_req.valid)
    else $error("request longer than one cycle");
  chk_req_gap: assert property (conv_done.valid |=> !conv_req.valid)
    else $error("request right after result");

  // ----------------------------------------
  // flag, interrupt and refusals
  // ----------------------------------------
  chk_pause_hold: assert property (conversion_end_irq |-> !conv_req.valid)
    else $error("request while paused on interrupt");
  chk_irq_cause: assert property ($rose(conversion_end_irq) |->
    $past(conv_done.valid) || $past(conv_done.valid, 2) || $past(psel && pwrite))
    else $error("interrupt without conversion end");
  chk_irq_drop: assert property ($fell(conversion_end_irq) |->
    $past(psel && penable) || $past(psel && penable, 2))
    else $error("interrupt dropped without access");
  chk_hole_read: assert property (psel && penable && pready && paddr == 8'h08
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_res_ro: assert property (psel && penable && pready && pwrite && paddr >= OFS_RES
    |-> pslverr)
    else $error("result write not refused");

  cov_irq: cover property ($rose(conversion_end_irq));
  cov_done: cover property (conv_done.valid);
  cov_err: cover property (pslverr);
endmodule : adcsb_props

/* testbench/adcsb_core_model.sv */
/*
 * adcsb_core_model: conversion core standing behind the sequencer.
 * assumes: one request at a time; answers alternate 4 and 10 cycles after acceptance.
 */
`timescale 1ns/10ps
module adcsb_core_model
  import adcsb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire adcsb_req_t req,
  output adcsb_done_t done
);
  logic [6:0] n_reg;
  logic [3:0] cnt_reg;
  logic [2:0] ch_reg;
  logic busy_reg;

  // data = channel and answer number, so chain order is visible
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_reg <= 7'h00;
      cnt_reg <= 4'h0;
      ch_reg <= 3'h0;
      busy_reg <= 1'b0;
      done <= '0;
    end else begin
      done.valid <= 1'b0;
      done.data <= ~done.data;
      if (req.valid && !busy_reg) begin
        busy_reg <= 1'b1;
        ch_reg <= req.chan;
        cnt_reg <= n_reg[0] ? 4'h9 : 4'h3;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        done.valid <= 1'b1;
        done.data <= {ch_reg, n_reg};
        n_reg <= n_reg + 7'h01;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : adcsb_core_model

/* testbench/adcsb_bench.sv */
/*
 * adcsb_bench: apb tests of the scan/buffer sequencer.
 * assumes: adcsb_core_model answers each request; zero-wait slave.
 */
`timescale 1ns/10ps
`define CHK(n, x, g) begin if ((g) !== (x)) begin $display("BAD %s exp %h got %h", n, x, g); err_count++; end checks_done++; end
module adcsb_bench
  import adcsb_pkg::*;
;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, conversion_end_irq;
  logic timer_trig = 1'b0, ext_trig_pin = 1'b0, xfer_ctrl_mode = 1'b0;
  adcsb_req_t conv_req;
  adcsb_done_t conv_done;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic [6:0] ndone = 7'h0, b;

  always #20 clk = ~clk;
  always @(posedge clk or negedge nrst) if (!nrst) ndone <= 7'h0;
    else if (conv_done.valid === 1'b1) ndone <= ndone + 7'h1;

  adcsb_top i_adcsb_top (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_trig(timer_trig), .ext_trig_pin(ext_trig_pin),
    .xfer_ctrl_mode(xfer_ctrl_mode), .conv_req(conv_req), .conv_done(conv_done),
    .conversion_end_irq(conversion_end_irq));
  adcsb_core_model i_adcsb_core_model (.clk(clk), .nrst(nrst), .req(conv_req),
    .done(conv_done));

  // ----------------------------------------
  // bus tasks and run control
  // ----------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task wait_flag;
    do apb(1'b0, OFS_CSR, 32'h0); while (q[7] !== 1'b1);
  endtask : wait_flag
  task wait_irq;
    while (conversion_end_irq !== 1'b1) @(posedge clk);
  endtask : wait_irq
  // one single run of a buffered setting; checks the count and one result
  task buf_run(input logic [1:0] c, input logic [7:0] s, input logic [6:0] cnt,
    input logic [2:0] ix, input logic [2:0] ch, input logic [6:0] age);
    apb(1'b1, OFS_CR, 32'h0);
    apb(1'b1, OFS_CR, {30'h0, c});
    b = ndone;
    apb(1'b1, OFS_CSR, {24'h0, s});
    wait_flag();
    apb(1'b1, OFS_CSR, 32'h0);
    `CHK("buf count", cnt, 7'(ndone - b))
    apb(1'b0, OFS_RES + 8'(4 * ix), 32'h0);
    `CHK("buf res", {22'h0, ch, 7'(b + cnt - 7'h1 - age)}, q)
  endtask : buf_run
  task test_done;
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, OFS_CSR, 32'h0); `CHK("csr", 32'h0, q)
    apb(1'b0, OFS_CR, 32'h0); `CHK("cr", 32'h0, q)
    apb(1'b0, 8'h08, 32'h0); `CHK("hole", 33'h100000000, {e, q})
    apb(1'b1, OFS_RES, 32'h3ff); `CHK("res wr", 1'b1, e)
    // four-stage, buffer only, four passes, single stops
    apb(1'b1, OFS_CR, 32'h3);
    b = ndone;
    apb(1'b1, OFS_CSR, 32'h33);
    wait_flag();
    repeat (40) @(posedge clk);
    `CHK("count", 7'h4, 7'(ndone - b))
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFS_RES + 8'(4 * i), 32'h0);
      `CHK("chain", {25'h0, 7'(b + 7'(3 - i))}, q)
    end
    // write 1 disarms; a zero write without fresh read keeps the flag
    apb(1'b1, OFS_CSR, 32'h80);
    apb(1'b1, OFS_CSR, 32'h0);
    apb(1'b0, OFS_CSR, 32'h0); `CHK("no clr", 1'b1, q[7])
    apb(1'b1, OFS_CSR, 32'h0);
    apb(1'b0, OFS_CSR, 32'h0); `CHK("clr", 32'h0, q)
    apb(1'b1, OFS_CR, 32'h0);
    apb(1'b0, OFS_CR, 32'h0); `CHK("cnt rst", 32'h0, q)
    // group scan over inputs 0 and 1, paused by the interrupt
    b = ndone;
    apb(1'b1, OFS_CSR, 32'h79);
    wait_irq();
    repeat (30) @(posedge clk);
    `CHK("pass", 7'h2, 7'(ndone - b))
    apb(1'b0, OFS_RES, 32'h0); `CHK("res a", {25'h0, b}, q)
    apb(1'b0, OFS_RES + 8'h4, 32'h0); `CHK("res b", {22'h0, 3'h1, 7'(b + 7'h1)}, q)
    apb(1'b0, OFS_CSR, 32'h0); `CHK("scan csr", 32'hf9, q)
    apb(1'b1, OFS_CSR, 32'h79);
    repeat (20) @(posedge clk);
    `CHK("resume", 1'b1, 7'(ndone - b) > 7'h2)
    apb(1'b1, OFS_CSR, 32'h0);
    repeat (40) @(posedge clk);
    // a flag raised just before the stop goes by read then zero write
    apb(1'b0, OFS_CSR, 32'h0);
    apb(1'b1, OFS_CSR, 32'h0);
    b = ndone;
    repeat (40) @(posedge clk);
    `CHK("stopped", b, ndone)
    `CHK("irq off", 1'b0, conversion_end_irq)
    // transfer engine mode: last result read clears the flag
    xfer_ctrl_mode <= 1'b1;
    apb(1'b1, OFS_CR, 32'h3);
    apb(1'b1, OFS_CSR, 32'h71);
    wait_irq();
    apb(1'b0, OFS_RES, 32'h0); `CHK("irq a", 1'b1, conversion_end_irq)
    apb(1'b0, OFS_RES + 8'h4, 32'h0); `CHK("irq b", 1'b0, conversion_end_irq)
    xfer_ctrl_mode <= 1'b0;
    apb(1'b1, OFS_CSR, 32'h0);
    apb(1'b1, OFS_CR, 32'h0);
    // buffer-only two-group, then the three combined codes
    buf_run(2'h2, 8'h32, 7'h4, 3'h3, 3'h1, 7'h2);
    buf_run(2'h1, 8'h33, 7'h3, 3'h3, 3'h3, 7'h0);
    buf_run(2'h3, 8'h36, 7'h4, 3'h6, 3'h6, 7'h0);
    buf_run(2'h2, 8'h34, 7'h3, 3'h4, 3'h4, 7'h0);
    // select single with a chain: one conversion per start
    apb(1'b1, OFS_CR, 32'h1);
    apb(1'b1, OFS_CSR, 32'h21);
    repeat (30) @(posedge clk);
    apb(1'b0, OFS_CSR, 32'h0); `CHK("standby", 32'h1, q)
    apb(1'b0, OFS_CR, 32'h0); `CHK("count one", 32'h101, q)
    apb(1'b1, OFS_CR, 32'h0);
    apb(1'b0, OFS_CR, 32'h0); `CHK("count clr", 32'h0, q)
    apb(1'b1, OFS_CR, 32'h1);
    b = ndone;
    apb(1'b1, OFS_CSR, 32'h21);
    repeat (30) @(posedge clk);
    apb(1'b1, OFS_CSR, 32'h21);
    wait_flag();
    apb(1'b1, OFS_CSR, 32'h0);
    `CHK("restarts", 7'h2, 7'(ndone - b))
    apb(1'b1, OFS_CR, 32'h0);
    // start by timer, then by the pin
    for (int t = 1; t < 4; t += 2) begin
      apb(1'b1, OFS_CR, 32'(t << 4));
      b = ndone;
      timer_trig <= (t == 1);
      ext_trig_pin <= (t == 3);
      @(posedge clk);
      timer_trig <= 1'b0;
      wait_flag();
      `CHK("trig", 7'h1, 7'(ndone - b))
      apb(1'b1, OFS_CSR, 32'h0);
      ext_trig_pin <= 1'b0;
    end
    test_done();
  end
endmodule : adcsb_bench

bind adcsb_top adcsb_props i_adcsb_props (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_req(conv_req), .conv_done(conv_done),
  .conversion_end_irq(conversion_end_irq));
